// ==== dic_top.sv ====
/*
  Eight-point discrete input conditioner with a plain register port.
  Assumes synchronous field inputs and a single 10 MHz clock with async reset.
*/
// Strobed register access and the address map were decided locally.
// Summary of operation
// R1 - Eight input points, each with its own polarity, state, persistence, filter.
// R2 - Polarity picks the active level: sourcing high (default) or sinking low.
// R3 - Normally open reports the active level; normally closed reports its absence.
// R4 - Persistence holds a new true value at least 15, 50 or 100 ms; default off.
// R5 - Filter reports true only after 3 (default), 10 or 20 ms continuously on.
// R6 - With filter and persistence both off, report follows the signal without delay or stretch.
// R7 - One indicator output per point shows whether that input is active.
// R8 - Stages run polarity, inversion, filter, persistence, timed by a common millisecond tick.
`timescale 1ns/10ps
module dic_top #(
  parameter int TICK_CYCLES = dic_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // Field inputs.
  input  wire logic [7:0]  FIELD_IN,
  // Register port.
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // Reported data and indicators.
  output logic      [7:0]  INPUT_DATA,
  output logic      [7:0]  INDICATOR
);

  logic [7:0]  polarity;
  logic [7:0]  opstate;
  logic [15:0] filt_sel;
  logic [15:0] pers_sel;
  logic [15:0] tcnt;
  logic [15:0] tick_gap;
  logic        tick;
  logic [7:0]  values;

  // Common millisecond tick for every point.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tcnt <= '0;
      tick <= 1'b0;
    end else if (tcnt == 16'(TICK_CYCLES - 1)) begin
      tcnt <= '0;
      tick <= 1'b1;  // [R8]
    end else begin
      tcnt <= tcnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // Cycles since the last tick, kept apart from the divider for the period checks.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tick_gap <= '0;
    end else if (tick) begin
      tick_gap <= '0;
    end else begin
      tick_gap <= tick_gap + 1'b1;
    end
  end

  // Configuration registers.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      polarity <= dic_pkg::RST_POLARITY;
      opstate  <= dic_pkg::RST_OPSTATE;
      filt_sel <= dic_pkg::RST_FILT_SEL;
      pers_sel <= dic_pkg::RST_PERS_SEL;
    end else if (REG_WR) begin
      if (REG_ADDR == dic_pkg::OFS_POLARITY) begin
        polarity <= REG_WDATA[7:0];  // [R1] [R2]
      end else if (REG_ADDR == dic_pkg::OFS_OPSTATE) begin
        opstate <= REG_WDATA[7:0];  // [R1] [R3]
      end else if (REG_ADDR == dic_pkg::OFS_FILT_SEL) begin
        filt_sel <= REG_WDATA[15:0];  // [R1] [R5]
      end else if (REG_ADDR == dic_pkg::OFS_PERS_SEL) begin
        pers_sel <= REG_WDATA[15:0];  // [R1] [R4]
      end
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= '0;
    end else if (!REG_RD) begin
      REG_RDATA <= '0;
    end else if (REG_ADDR == dic_pkg::OFS_POLARITY) begin
      REG_RDATA <= {24'h000000, polarity};
    end else if (REG_ADDR == dic_pkg::OFS_OPSTATE) begin
      REG_RDATA <= {24'h000000, opstate};
    end else if (REG_ADDR == dic_pkg::OFS_FILT_SEL) begin
      REG_RDATA <= {16'h0000, filt_sel};
    end else if (REG_ADDR == dic_pkg::OFS_PERS_SEL) begin
      REG_RDATA <= {16'h0000, pers_sel};
    end else if (REG_ADDR == dic_pkg::OFS_DATA) begin
      REG_RDATA <= {24'h000000, INPUT_DATA};
    end else if (REG_ADDR == dic_pkg::OFS_PINS) begin
      REG_RDATA <= {24'h000000, FIELD_IN};
    end else begin
      REG_RDATA <= '0;
    end
  end

  // One independent conditioning stage per point.
  for (genvar g = 0; g < dic_pkg::NUM_POINTS; g++) begin : g_point
    dic_point_if pif ();
    assign pif.tick     = tick;
    assign pif.pin      = FIELD_IN[g];
    assign pif.sinking  = polarity[g];
    assign pif.nclosed  = opstate[g];
    assign pif.filt_sel = dic_pkg::dic_sel_t'(filt_sel[2*g +: 2]);
    assign pif.pers_sel = dic_pkg::dic_sel_t'(pers_sel[2*g +: 2]);
    assign values[g]    = pif.value;
    dic_point u_point (  // [R1]
      .clk (SYS_CLK),
      .rst (RST),
      .pif (pif.point)
    );
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      INPUT_DATA <= '0;
      INDICATOR  <= '0;
    end else begin
      INPUT_DATA <= values;
      INDICATOR  <= values;  // [R7]
    end
  end

  AST_TICK_SINGLE: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R8]
    tick |=> !tick)
    else $error("Millisecond tick lasted more than one cycle.");

  AST_TICK_PHASE: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R8]
    tick |-> tcnt == '0)
    else $error("Millisecond tick out of phase with its counter.");

  AST_INDICATOR: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R7]
    ##1 INDICATOR == $past(values))
    else $error("Indicator does not show the point state.");

  AST_CFG_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R1]
    (REG_WR && REG_ADDR == dic_pkg::OFS_POLARITY) |=> polarity == $past(REG_WDATA[7:0]))
    else $error("Polarity write not taken.");

  AST_READ_DATA: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R1]
    (REG_RD && REG_ADDR == dic_pkg::OFS_DATA) |=> REG_RDATA == {24'h000000, $past(INPUT_DATA)})
    else $error("Data register read returns the wrong value.");

  // A tick neither comes early nor goes missing, so both windows keep their length.
  AST_TICK_EARLY: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R8]
    tick |-> tick_gap >= 16'(TICK_CYCLES - 1))
    else $error("Millisecond tick came early.");

  AST_TICK_LATE: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R8]
    !tick |-> tick_gap <= 16'(TICK_CYCLES - 1))
    else $error("Millisecond tick was skipped.");

  AST_CFG_OPSTATE: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R3]
    (REG_WR && REG_ADDR == dic_pkg::OFS_OPSTATE) |=> opstate == $past(REG_WDATA[7:0]))
    else $error("Operating-state write not taken.");

  AST_CFG_FILT: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R5]
    (REG_WR && REG_ADDR == dic_pkg::OFS_FILT_SEL) |=> filt_sel == $past(REG_WDATA[15:0]))
    else $error("Filter select write not taken.");

  AST_CFG_PERS: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R4]
    (REG_WR && REG_ADDR == dic_pkg::OFS_PERS_SEL) |=> pers_sel == $past(REG_WDATA[15:0]))
    else $error("Persistence select write not taken.");

  AST_CFG_STABLE: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R1]
    !REG_WR |=> $stable(polarity) && $stable(opstate) &&
                $stable(filt_sel) && $stable(pers_sel))
    else $error("Configuration changed without a write.");

  AST_CFG_IGNORED: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R1]
    (REG_WR && REG_ADDR != dic_pkg::OFS_POLARITY && REG_ADDR != dic_pkg::OFS_OPSTATE &&
     REG_ADDR != dic_pkg::OFS_FILT_SEL && REG_ADDR != dic_pkg::OFS_PERS_SEL) |=>
    $stable(polarity) && $stable(opstate) && $stable(filt_sel) && $stable(pers_sel))
    else $error("Write to a read-only or unmapped address changed the configuration.");

  AST_RD_IDLE: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R1]
    !REG_RD |=> REG_RDATA == '0)
    else $error("Read data stood longer than one cycle.");

  AST_READ_PINS: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R1]
    (REG_RD && REG_ADDR == dic_pkg::OFS_PINS) |=>
    REG_RDATA == {24'h000000, $past(FIELD_IN)})
    else $error("Pin register read returns the wrong value.");

  AST_READ_POLARITY: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R2]
    (REG_RD && REG_ADDR == dic_pkg::OFS_POLARITY) |=>
    REG_RDATA == {24'h000000, $past(polarity)})
    else $error("Polarity read-back differs from the register.");

  AST_READ_OPSTATE: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R3]
    (REG_RD && REG_ADDR == dic_pkg::OFS_OPSTATE) |=>
    REG_RDATA == {24'h000000, $past(opstate)})
    else $error("Operating-state read-back differs from the register.");

  AST_READ_FILT: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R5]
    (REG_RD && REG_ADDR == dic_pkg::OFS_FILT_SEL) |=>
    REG_RDATA == {16'h0000, $past(filt_sel)})
    else $error("Filter select read-back differs from the register.");

  AST_READ_PERS: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R4]
    (REG_RD && REG_ADDR == dic_pkg::OFS_PERS_SEL) |=>
    REG_RDATA == {16'h0000, $past(pers_sel)})
    else $error("Persistence select read-back differs from the register.");

  AST_DATA_FOLLOW: assert property (@(posedge SYS_CLK) disable iff (RST)  // [R6]
    ##1 INPUT_DATA == $past(values))
    else $error("Reported data do not follow the point values.");

  COV_CFG_WRITE: cover property (@(posedge SYS_CLK) disable iff (RST)
    REG_WR && REG_ADDR == dic_pkg::OFS_PERS_SEL);
  COV_ALL_ON: cover property (@(posedge SYS_CLK) disable iff (RST)
    INPUT_DATA == 8'hff);
  COV_READ_PINS: cover property (@(posedge SYS_CLK) disable iff (RST)
    REG_RD && REG_ADDR == dic_pkg::OFS_PINS);

endmodule

// ==== dic_pkg.sv ====
/*
  Shared constants and types for the discrete input conditioner.
  Assumes a single 10 MHz system clock and a one-millisecond time base.
*/
package dic_pkg;

  // System clock rate, and the resulting length of the millisecond tick.
  localparam int CLK_HZ      = 10000000;
  localparam int TICK_HZ     = 1000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;

  localparam int NUM_POINTS = 8;
  localparam int SEL_W      = 2;
  localparam int CNT_W      = 7;

  // Register byte offsets.
  localparam logic [7:0] OFS_POLARITY = 8'h00;
  localparam logic [7:0] OFS_OPSTATE  = 8'h04;
  localparam logic [7:0] OFS_FILT_SEL = 8'h08;
  localparam logic [7:0] OFS_PERS_SEL = 8'h0c;
  localparam logic [7:0] OFS_DATA     = 8'h10;
  localparam logic [7:0] OFS_PINS     = 8'h14;

  // Reset values: sourcing, normally open, 3 ms filter, persistence off.
  localparam logic [7:0]  RST_POLARITY = 8'h00;
  localparam logic [7:0]  RST_OPSTATE  = 8'h00;
  localparam logic [15:0] RST_FILT_SEL = 16'h5555;
  localparam logic [15:0] RST_PERS_SEL = 16'h0000;

  // Window lengths in milliseconds.
  localparam int FILT_A_MS = 3;
  localparam int FILT_B_MS = 10;
  localparam int FILT_C_MS = 20;
  localparam int PERS_A_MS = 15;
  localparam int PERS_B_MS = 50;
  localparam int PERS_C_MS = 100;

  // Tick counts: one extra tick because the first tick may follow almost at once.
  localparam logic [CNT_W-1:0] FILT_A_TICKS = CNT_W'(FILT_A_MS + 1);
  localparam logic [CNT_W-1:0] FILT_B_TICKS = CNT_W'(FILT_B_MS + 1);
  localparam logic [CNT_W-1:0] FILT_C_TICKS = CNT_W'(FILT_C_MS + 1);
  localparam logic [CNT_W-1:0] PERS_A_TICKS = CNT_W'(PERS_A_MS + 1);
  localparam logic [CNT_W-1:0] PERS_B_TICKS = CNT_W'(PERS_B_MS + 1);
  localparam logic [CNT_W-1:0] PERS_C_TICKS = CNT_W'(PERS_C_MS + 1);

  typedef enum logic [SEL_W-1:0] {
    SEL_OFF = 2'b00,
    SEL_A   = 2'b01,
    SEL_B   = 2'b10,
    SEL_C   = 2'b11
  } dic_sel_t;

endpackage

// ==== dic_point_if.sv ====
/*
  Per-point carrier between the conditioner top and one point stage.
  Assumes the top drives the configuration and tick, the point drives the value.
*/
`timescale 1ns/10ps
interface dic_point_if;
  logic              tick;
  logic              pin;
  logic              sinking;
  logic              nclosed;
  dic_pkg::dic_sel_t filt_sel;
  dic_pkg::dic_sel_t pers_sel;
  logic              value;

  modport ctrl (
    output tick, pin, sinking, nclosed, filt_sel, pers_sel,
    input  value
  );
  modport point (
    input  tick, pin, sinking, nclosed, filt_sel, pers_sel,
    output value
  );
endinterface

// ==== dic_point.sv ====
/*
  One input point: polarity, operating state, qualification filter, persistence.
  Assumes a one-cycle millisecond tick and configuration held steady by the top.
*/
`timescale 1ns/10ps
module dic_point (
  // Clock and reset.
  input wire logic  clk,
  input wire logic  rst,
  // Point signals.
  dic_point_if.point pif
);

  logic [dic_pkg::CNT_W-1:0] fcnt;
  logic [dic_pkg::CNT_W-1:0] hcnt;
  logic [dic_pkg::CNT_W-1:0] filt_thr;
  logic [dic_pkg::CNT_W-1:0] pers_thr;
  logic                      cond;
  logic                      qual;
  logic                      qual_d;

  function automatic logic [dic_pkg::CNT_W-1:0] filt_ticks(input dic_pkg::dic_sel_t s);
    case (s)
      dic_pkg::SEL_A: filt_ticks = dic_pkg::FILT_A_TICKS;
      dic_pkg::SEL_B: filt_ticks = dic_pkg::FILT_B_TICKS;
      dic_pkg::SEL_C: filt_ticks = dic_pkg::FILT_C_TICKS;
      default:        filt_ticks = '0;
    endcase
  endfunction

  function automatic logic [dic_pkg::CNT_W-1:0] pers_ticks(input dic_pkg::dic_sel_t s);
    case (s)
      dic_pkg::SEL_A: pers_ticks = dic_pkg::PERS_A_TICKS;
      dic_pkg::SEL_B: pers_ticks = dic_pkg::PERS_B_TICKS;
      dic_pkg::SEL_C: pers_ticks = dic_pkg::PERS_C_TICKS;
      default:        pers_ticks = '0;
    endcase
  endfunction

  assign filt_thr = filt_ticks(pif.filt_sel);
  assign pers_thr = pers_ticks(pif.pers_sel);
  // Polarity first, then the normally-closed inversion.
  assign cond = (pif.pin ^ pif.sinking) ^ pif.nclosed;  // [R2] [R3] [R8]
  // With the filter off the conditioned signal passes straight through.
  assign qual = cond && ((filt_thr == '0) || (fcnt >= filt_thr));  // [R5] [R6] [R8]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fcnt <= '0;
    end else if (!cond) begin
      fcnt <= '0;  // [R5]
    end else if (pif.tick && (fcnt < filt_thr)) begin
      fcnt <= fcnt + 1'b1;  // [R5]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qual_d <= 1'b0;
      hcnt   <= '0;
    end else begin
      qual_d <= qual;
      if (qual && !qual_d) begin
        hcnt <= pers_thr;  // [R4]
      end else if (pif.tick && (hcnt != '0)) begin
        hcnt <= hcnt - 1'b1;  // [R4]
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pif.value <= 1'b0;
    end else begin
      pif.value <= qual || (hcnt != '0);  // [R4] [R6]
    end
  end

  AST_SOURCE_NO: assert property (@(posedge clk) disable iff (rst)  // [R2]
    (!pif.sinking && !pif.nclosed && filt_thr == '0 && hcnt == '0 && pers_thr == '0)
    |=> pif.value == $past(pif.pin))
    else $error("Sourcing normally-open point does not follow its pin.");

  AST_SINK_NO: assert property (@(posedge clk) disable iff (rst)  // [R2]
    (pif.sinking && !pif.nclosed && filt_thr == '0 && hcnt == '0 && pers_thr == '0)
    |=> pif.value == !$past(pif.pin))
    else $error("Sinking point does not report a low pin as true.");

  AST_NC_INVERT: assert property (@(posedge clk) disable iff (rst)  // [R3]
    (!pif.sinking && pif.nclosed && filt_thr == '0 && hcnt == '0 && pers_thr == '0)
    |=> pif.value == !$past(pif.pin))
    else $error("Normally-closed point does not invert.");

  AST_FILT_QUALIFY: assert property (@(posedge clk) disable iff (rst)  // [R5]
    ($rose(pif.value) && $past(filt_thr) != '0) |-> $past(fcnt) >= $past(filt_thr))
    else $error("Filtered point turned on before its window elapsed.");

  AST_FILT_CLEAR: assert property (@(posedge clk) disable iff (rst)  // [R5]
    !cond |=> fcnt == '0)
    else $error("Filter count survived a dropout.");

  AST_HOLD_LOAD: assert property (@(posedge clk) disable iff (rst)  // [R4]
    (qual && !qual_d) |=> hcnt == $past(pers_thr))
    else $error("Hold counter not loaded on a rising value.");

  AST_HOLD_VALUE: assert property (@(posedge clk) disable iff (rst)  // [R4]
    (hcnt != '0) |=> pif.value)
    else $error("Value dropped while the hold window was running.");

  COV_FILTERED_ON: cover property (@(posedge clk) disable iff (rst)
    $rose(pif.value) && filt_thr != '0);
  COV_STRETCHED: cover property (@(posedge clk) disable iff (rst)
    !cond && hcnt != '0 ##1 pif.value);

endmodule

// ==== dic_field_model.sv ====
/*
  Field sensors on the eight discrete input points.
  Assumes the bench sets the wanted pin levels; sensors always drive their pins.
*/
`timescale 1ns/10ps
module dic_field_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Wanted levels and pins.
  input  wire logic [7:0] level_req,
  output logic      [7:0] field
);
  // Pins settle on the clock, as a synchronised field input would.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      field <= 8'h00;
    end else begin
      field <= level_req;
    end
  end
endmodule

// ==== dic_top_tb.sv ====
/*
  Self-checking bench for the discrete input conditioner.
  Assumes a short millisecond tick of TICK cycles so windows finish quickly.
*/
`timescale 1ns/10ps
module dic_top_tb;
  localparam int TICK = 10;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  req_level = 8'h00;
  logic [7:0]  field;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  input_data;
  logic [7:0]  indicator;
  logic [31:0] rdv;
  logic [7:0]  pat [4][3] = '{'{8'h0f, 8'h00, 8'h00}, '{8'h0f, 8'hff, 8'h00},
                              '{8'h0f, 8'h33, 8'h55}, '{8'hc3, 8'h00, 8'hff}};
  int          fms [3] = '{dic_pkg::FILT_A_MS, dic_pkg::FILT_B_MS, dic_pkg::FILT_C_MS};
  int          pms [3] = '{dic_pkg::PERS_A_MS, dic_pkg::PERS_B_MS, dic_pkg::PERS_C_MS};
  int          rise [8];
  int          fall [8];
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  dic_field_model sens_u (.clk(clk), .rst(rst), .level_req(req_level), .field(field));

  dic_top #(.TICK_CYCLES(TICK)) dut_u (
    .SYS_CLK(clk), .RST(rst), .FIELD_IN(field), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .INPUT_DATA(input_data), .INDICATOR(indicator)
  );

  task end_of_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Drives lvl for width cycles, records each point's first rise and fall.
  task pulse(input logic [7:0] lvl, input int width, input int total);
    for (int g = 0; g < 8; g++) begin
      rise[g] = -1;
      fall[g] = -1;
    end
    for (int i = 0; i < total; i++) begin
      @(posedge clk);
      if (i == 0) req_level <= lvl;
      if (i == width) req_level <= 8'h00;
      #1;
      for (int g = 0; g < 8; g++) begin
        if (input_data[g] === 1'b1 && rise[g] < 0) rise[g] = i;
        if (input_data[g] === 1'b0 && rise[g] >= 0 && fall[g] < 0) fall[g] = i;
      end
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(dic_pkg::OFS_POLARITY, rdv);
    check("polarity reset", rdv, {24'h0, dic_pkg::RST_POLARITY});
    rd(dic_pkg::OFS_OPSTATE, rdv);
    check("opstate reset", rdv, {24'h0, dic_pkg::RST_OPSTATE});
    rd(dic_pkg::OFS_FILT_SEL, rdv);
    check("filter reset", rdv, {16'h0, dic_pkg::RST_FILT_SEL});
    rd(dic_pkg::OFS_PERS_SEL, rdv);
    check("persist reset", rdv, {16'h0, dic_pkg::RST_PERS_SEL});
    wr(dic_pkg::OFS_DATA, 32'hff);
    rd(dic_pkg::OFS_DATA, rdv);
    check("data readonly", rdv, 32'h0);
    rd(8'h20, rdv);
    check("unmapped read", rdv, 32'h0);
    // Default 3 ms filter on every point.
    pulse(8'hff, 999, 6 * TICK);
    for (int g = 0; g < 8; g++) begin
      check("default filter", 32'(rise[g] >= 3 * TICK && rise[g] <= 4 * TICK + 3), 32'h1);
    end
    wr(dic_pkg::OFS_FILT_SEL, 32'h0);
    foreach (pat[k]) begin
      wr(dic_pkg::OFS_POLARITY, {24'h0, pat[k][1]});
      wr(dic_pkg::OFS_OPSTATE, {24'h0, pat[k][2]});
      pulse(pat[k][0], 999, 5);
      check("conditioned", {24'h0, input_data}, {24'h0, pat[k][0] ^ pat[k][1] ^ pat[k][2]});
      check("indicator", {24'h0, indicator}, {24'h0, pat[k][0] ^ pat[k][1] ^ pat[k][2]});
      rd(dic_pkg::OFS_PINS, rdv);
      check("pins", rdv, {24'h0, pat[k][0]});
    end
    wr(dic_pkg::OFS_POLARITY, 32'h0);
    wr(dic_pkg::OFS_OPSTATE, 32'h0);
    pulse(8'h00, 1, 5);
    wr(dic_pkg::OFS_FILT_SEL, 32'h39);
    // Short pulse: only the 3 ms point qualifies; point 3 follows exactly.
    pulse(8'h0f, 5 * TICK, 6 * TICK);
    check("short pulse 3ms", 32'(rise[0] >= 0), 32'h1);
    check("short pulse 10ms", 32'(rise[1]), 32'hffffffff);
    check("short pulse 20ms", 32'(rise[2]), 32'hffffffff);
    check("unfiltered rise", 32'(rise[3]), 32'h3);
    check("unfiltered fall", 32'(fall[3]), 32'(5 * TICK + 3));
    pulse(8'h0f, 999, 22 * TICK);
    for (int g = 0; g < 3; g++) begin
      check("filter window", 32'(rise[g] >= fms[g] * TICK && rise[g] <= (fms[g] + 1) * TICK + 3), 32'h1);
    end
    pulse(8'h00, 1, 5);
    wr(dic_pkg::OFS_FILT_SEL, 32'h0);
    wr(dic_pkg::OFS_PERS_SEL, 32'h39);
    pulse(8'h0f, 2, 105 * TICK);
    for (int g = 0; g < 3; g++) begin
      check("persist rise", 32'(rise[g]), 32'h3);
      check("persist hold", 32'(fall[g] - rise[g] >= pms[g] * TICK && fall[g] - rise[g] <= (pms[g] + 1) * TICK + 3), 32'h1);
    end
    check("unstretched fall", 32'(fall[3]), 32'h5);
    // A pulse rejected by the filter must not be stretched.
    wr(dic_pkg::OFS_FILT_SEL, 32'h1);
    pulse(8'h01, TICK, 5 * TICK);
    check("filter before persist", 32'(rise[0]), 32'hffffffff);
    end_of_test();
  end
endmodule
